// ===== pkg/sdram_sig_pkg.sv
// Constants for the memory module pin logic.
// Assumes a 125 MHz core clock and a separate data-strobe link clock.
package sdram_sig_pkg;
    localparam int          DQ_WIDTH        = 16;
    localparam int          LANE_COUNT      = 2;
    localparam int          BEAT_COUNT      = 8;
    localparam int          CA_WIDTH        = 22;
    localparam int          CFG_X4          = 0;
    localparam int          CFG_X8          = 1;
    localparam int          CFG_X16         = 2;
    localparam logic [1:0]  WIDTH_X4        = 2'h0;
    localparam logic [1:0]  WIDTH_X8        = 2'h1;
    localparam logic [1:0]  WIDTH_X16       = 2'h2;
    localparam logic [3:0]  CMD_READ        = 4'h5;
    localparam logic [3:0]  CMD_WRITE       = 4'h4;
    localparam int          MR5_PAR_BIT     = 0;
    localparam int          MR5_DM_BIT      = 10;
    localparam int          MR5_WDBI_BIT    = 11;
    localparam int          MR5_RDBI_BIT    = 12;
    localparam int          MR1_TDQS_BIT    = 11;
    localparam int          MR4_VREF_BIT    = 4;
    localparam int          MR2_CRC_BIT     = 12;
    localparam int          CLK_MHZ         = 125;
    localparam int          CRC_ALERT_NS    = 96;
    localparam int          CRC_ALERT_CYC   = (CRC_ALERT_NS * CLK_MHZ + 999) / 1000;
    localparam int          PAR_RECOV_NS    = 200;
    localparam int          PAR_RECOV_CYC   = (PAR_RECOV_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  CRC8_POLY       = 8'h07;
endpackage : sdram_sig_pkg

// ===== verilog/strobe_lane_capture.sv
// Strobe-domain write capture for one byte lane plus burst-complete toggle.
// Assumes the link clock runs only during bursts and the core reads after the toggle.
`timescale 1ns/1ps
`default_nettype none
module strobe_lane_capture
(
    input  wire logic        link_clk_in,
    input  wire logic        link_start_in,
    input  wire logic [7:0]  dq_rise_in,
    input  wire logic [7:0]  dq_fall_in,
    input  wire logic        mask_rise_low_in,
    input  wire logic        mask_fall_low_in,
    output logic [63:0]      beats_out,
    output logic [7:0]       keep_out,
    output logic [7:0]       crc_out,
    output logic             done_tgl_out
);
    logic [2:0] idx_ff;
    logic       in_crc_ff;

    // =========================================
    // Capture
    // Both strobe phases arrive as a pair per link edge, so data and mask share the
    // same sampling point. A plain process is used because the link side has no reset and
    // its state is given a start value once.
    always @(posedge link_clk_in)
    begin
        if (link_start_in)
        begin
            idx_ff    <= 3'h0;
            in_crc_ff <= 1'b0;
        end
        else if (!in_crc_ff)
        begin
            beats_out[idx_ff*8 +: 8]  <= dq_rise_in;
            beats_out[idx_ff*8+8 +: 8] <= dq_fall_in;
            keep_out[idx_ff]          <= mask_rise_low_in;
            keep_out[idx_ff+3'h1]     <= mask_fall_low_in;
            idx_ff                    <= idx_ff + 3'h2;
            if (idx_ff == 3'h6)
                in_crc_ff <= 1'b1;
        end
        else
        begin
            crc_out      <= dq_rise_in;
            in_crc_ff    <= 1'b0;
            idx_ff       <= 3'h0;
            done_tgl_out <= ~done_tgl_out;
        end
    end

    initial
    begin
        done_tgl_out = 1'b0;
        idx_ff       = 3'h0;
        in_crc_ff    = 1'b0;
        beats_out    = 64'h0;
        keep_out     = 8'h0;
        crc_out      = 8'h0;
    end
endmodule : strobe_lane_capture
`default_nettype wire

// ===== verilog/sdram_module_signal_logic.sv
// Pin logic of a single-rank memory module toward its controller.
// Assumes a core clock, an asynchronous active-low pin reset and a strobe link clock.
// Summary of operation
// - Termination control sampled high turns on data-side termination.
// - Termination disabled in mode registers makes termination control ignored.
// - Termination covers data, strobes and mask lanes per width configuration.
// - Parity, when enabled, covers activate, three command lines, bank and address.
// - Activate low makes command lines row address bits sixteen to fourteen.
// - Active-low reset input is taken asynchronously; the device clears on the next core clock edge.
// - Data bus width is 4, 8 or 16 bits per configuration.
// - With CRC enabled a CRC code follows the last data beat.
// - Mode register four bit four lets data lanes 0-3 monitor reference.
// - A beat with write mask sampled low is not stored.
// - Write mask is sampled on both strobe edges like data.
// - Mode register five selects mask or inversion; x8 mode one selects strobe.
// - Inversion lane low inverts data on store and output.
// - Device drives read strobe edge-aligned; controller centres write strobe.
// - In x16 the lower strobe times bits 7-0, upper bits 15-8.
// - Strobes exist only as differential pairs.
// - A write CRC mismatch pulls alert low for an interval then releases.
// - A parity failure holds alert low until recovery completes.
// - In connectivity test mode the alert pin becomes an input.
// - Temperature event output asserts when critical threshold exceeded.
// - Termination strobe exists only in x8 and stays off otherwise.
// - Commands sampled with chip select high are ignored.
// - Command inputs are captured on the rising true clock edge.
`timescale 1ns/1ps
`default_nettype none
module sdram_module_signal_logic
(
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    input  wire logic        reset_low_in,
    input  wire logic        link_clk_in,
    input  wire logic [1:0]  width_cfg_in,
    input  wire logic [17:0] mode_reg_one_in,
    input  wire logic [17:0] mode_reg_two_in,
    input  wire logic [17:0] mode_reg_four_in,
    input  wire logic [17:0] mode_reg_five_in,
    input  wire logic        termination_enable_in,
    input  wire logic        termination_control_in,
    input  wire logic        chip_select_low_in,
    input  wire logic        activate_select_in,
    input  wire logic        row_strobe_addr_hi_in,
    input  wire logic        column_strobe_addr_mid_in,
    input  wire logic        write_strobe_addr_lo_in,
    input  wire logic [1:0]  bank_group_bits_in,
    input  wire logic [1:0]  bank_bits_in,
    input  wire logic [13:0] addr_low_in,
    input  wire logic        parity_in,
    input  wire logic        link_start_in,
    input  wire logic [15:0] dq_rise_in,
    input  wire logic [15:0] dq_fall_in,
    input  wire logic [1:0]  write_mask_low_rise_in,
    input  wire logic [1:0]  write_mask_low_fall_in,
    input  wire logic [1:0]  bus_inversion_low_rise_in,
    input  wire logic [1:0]  bus_inversion_low_fall_in,
    input  wire logic [15:0] rd_data_in,
    input  wire logic        rd_valid_in,
    input  wire logic        conn_test_in,
    input  wire logic        alert_low_pin_in,
    input  wire logic        temp_critical_in,
    output logic [15:0]      dq_out,
    output logic [15:0]      dq_oe_out,
    output logic [1:0]       bus_inversion_low_out,
    output logic [1:0]       strobe_true_out,
    output logic [1:0]       strobe_comp_out,
    output logic [1:0]       strobe_oe_out,
    output logic             term_strobe_oe_out,
    output logic             termination_resistance_out,
    output logic [1:0]       lane_term_out,
    output logic             term_strobe_term_out,
    output logic             vref_monitor_out,
    output logic             alert_low_out,
    output logic             alert_low_oe_out,
    output logic             alert_seen_out,
    output logic             event_low_out,
    output logic             cmd_valid_out,
    output logic [3:0]       cmd_code_out,
    output logic [16:0]      row_addr_out,
    output logic             parity_err_out,
    output logic             crc_err_out,
    output logic [127:0]     wr_data_out,
    output logic [15:0]      wr_keep_out,
    output logic             wr_valid_out
);
    typedef enum {ALERT_IDLE, ALERT_CRC, ALERT_PAR} alert_state_t;

    // =========================================
    // Reset and configuration
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst;
    logic is_x8;
    logic is_x16;
    logic par_en;
    logic mask_en;
    logic wdbi_en;
    logic rdbi_en;
    logic tdqs_en;
    logic crc_en;

    // The pin reset is asserted asynchronously and released through two stages.
    always_ff @(posedge ref_clk_in or negedge reset_low_in)
    begin
        if (!reset_low_in)
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= 1'b1;
        end
        else
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign rst     = reset_in | rst_sync_ff;
    assign is_x8   = (width_cfg_in == sdram_sig_pkg::WIDTH_X8);
    assign is_x16  = (width_cfg_in == sdram_sig_pkg::WIDTH_X16);
    assign par_en  = mode_reg_five_in[sdram_sig_pkg::MR5_PAR_BIT];
    assign tdqs_en = is_x8 & mode_reg_one_in[sdram_sig_pkg::MR1_TDQS_BIT];
    assign mask_en = mode_reg_five_in[sdram_sig_pkg::MR5_DM_BIT] & ~tdqs_en;
    assign wdbi_en = mode_reg_five_in[sdram_sig_pkg::MR5_WDBI_BIT] & ~tdqs_en;
    assign rdbi_en = mode_reg_five_in[sdram_sig_pkg::MR5_RDBI_BIT] & ~tdqs_en;
    assign crc_en  = mode_reg_two_in[sdram_sig_pkg::MR2_CRC_BIT];

    // =========================================
    // Termination
    logic [1:0] odt_sync_ff;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst)
            odt_sync_ff <= 2'h0;
        else
            odt_sync_ff <= {odt_sync_ff[0], termination_control_in};
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst)
        begin
            termination_resistance_out <= 1'b0;
            lane_term_out              <= 2'h0;
            term_strobe_term_out       <= 1'b0;
        end
        else
        begin
            termination_resistance_out <= termination_enable_in & odt_sync_ff[1];
            lane_term_out[0]           <= termination_enable_in & odt_sync_ff[1];
            lane_term_out[1]           <= termination_enable_in & odt_sync_ff[1] & is_x16;
            term_strobe_term_out       <= termination_enable_in & odt_sync_ff[1] & tdqs_en;
        end
    end

    assign term_strobe_oe_out = 1'b0;
    assign vref_monitor_out   = mode_reg_four_in[sdram_sig_pkg::MR4_VREF_BIT];

    // =========================================
    // Command, address and parity
    // Command pins are already registered to the core clock by the pad ring.
    logic [sdram_sig_pkg::CA_WIDTH-1:0] ca_vec;
    logic                               par_bad;
    logic                               cmd_take;

    assign ca_vec   = {activate_select_in, row_strobe_addr_hi_in, column_strobe_addr_mid_in,
                       write_strobe_addr_lo_in, bank_group_bits_in, bank_bits_in, addr_low_in};
    assign par_bad  = par_en & ((^ca_vec) ^ parity_in);
    assign cmd_take = ~chip_select_low_in;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst)
        begin
            cmd_valid_out  <= 1'b0;
            cmd_code_out   <= 4'h0;
            row_addr_out   <= 17'h0;
            parity_err_out <= 1'b0;
        end
        else
        begin
            cmd_valid_out  <= cmd_take & ~par_bad;
            parity_err_out <= cmd_take & par_bad;
            if (cmd_take & ~activate_select_in)
                row_addr_out <= {row_strobe_addr_hi_in, column_strobe_addr_mid_in,
                                 write_strobe_addr_lo_in, addr_low_in};
            if (cmd_take & activate_select_in)
                cmd_code_out <= {1'b0, row_strobe_addr_hi_in, column_strobe_addr_mid_in,
                                 write_strobe_addr_lo_in};
            else
                cmd_code_out <= 4'h0;
        end
    end

    // =========================================
    // Write capture in the strobe domain
    logic [63:0] lane_beats [sdram_sig_pkg::LANE_COUNT];
    logic [7:0]  lane_keep  [sdram_sig_pkg::LANE_COUNT];
    logic [7:0]  lane_crc   [sdram_sig_pkg::LANE_COUNT];
    logic [1:0]  lane_tgl;
    logic [2:0]  tgl_sync_ff;
    logic [7:0]  calc_crc   [sdram_sig_pkg::LANE_COUNT];
    logic [1:0]  lane_crc_bad;
    logic        burst_done;

    genvar g;
    generate
        for (g = 0; g < sdram_sig_pkg::LANE_COUNT; g++)
        begin : g_lane
            logic [7:0] dq_r;
            logic [7:0] dq_f;
            // Lane 0 serves x4 and x8; in x16 the lower strobe times lane 0, upper lane 1.
            assign dq_r = dq_rise_in[g*8 +: 8] ^ {8{wdbi_en & ~bus_inversion_low_rise_in[g]}};
            assign dq_f = dq_fall_in[g*8 +: 8] ^ {8{wdbi_en & ~bus_inversion_low_fall_in[g]}};
            strobe_lane_capture u_cap
            (
                .link_clk_in      (link_clk_in),
                .link_start_in    (link_start_in),
                .dq_rise_in       (dq_r),
                .dq_fall_in       (dq_f),
                .mask_rise_low_in (write_mask_low_rise_in[g] | ~mask_en),
                .mask_fall_low_in (write_mask_low_fall_in[g] | ~mask_en),
                .beats_out        (lane_beats[g]),
                .keep_out         (lane_keep[g]),
                .crc_out          (lane_crc[g]),
                .done_tgl_out     (lane_tgl[g])
            );

            always_comb
            begin
                calc_crc[g] = 8'h00;
                for (int b = 0; b < 64; b++)
                    calc_crc[g] = {calc_crc[g][6:0], 1'b0}
                                ^ ({8{calc_crc[g][7] ^ lane_beats[g][b]}} & sdram_sig_pkg::CRC8_POLY);
            end
            assign lane_crc_bad[g] = (calc_crc[g] != lane_crc[g]);
        end
    endgenerate

    // Lane 0 toggles on every burst in every width, so its toggle marks every burst.
    // The chain keeps shifting through reset, so a toggle left over from before a
    // mid-run reset does not show up as a false burst afterwards.
    always_ff @(posedge ref_clk_in)
    begin
        tgl_sync_ff <= {tgl_sync_ff[1:0], lane_tgl[0]};
    end

    assign burst_done = tgl_sync_ff[2] ^ tgl_sync_ff[1];

    always_ff @(posedge ref_clk_in)
    begin
        if (rst)
        begin
            wr_valid_out <= 1'b0;
            wr_data_out  <= 128'h0;
            wr_keep_out  <= 16'h0;
            crc_err_out  <= 1'b0;
        end
        else
        begin
            wr_valid_out <= burst_done;
            crc_err_out  <= burst_done & crc_en & (lane_crc_bad[0] | (is_x16 & lane_crc_bad[1]));
            if (burst_done)
            begin
                wr_data_out <= {lane_beats[1], lane_beats[0]};
                wr_keep_out <= {lane_keep[1] & {8{is_x16}}, lane_keep[0]};
            end
        end
    end

    // =========================================
    // Read path: strobe driven as a differential pair aligned to data edges
    always_ff @(posedge ref_clk_in)
    begin
        if (rst)
        begin
            dq_out                <= 16'h0;
            dq_oe_out             <= 16'h0;
            bus_inversion_low_out <= 2'h3;
            strobe_true_out       <= 2'h0;
            strobe_comp_out       <= 2'h3;
            strobe_oe_out         <= 2'h0;
        end
        else
        begin
            dq_out                <= rd_data_in;
            bus_inversion_low_out <= 2'h3;
            if (rd_valid_in & rdbi_en)
            begin
                for (int l = 0; l < sdram_sig_pkg::LANE_COUNT; l++)
                    if ($countones(rd_data_in[l*8 +: 8]) > 4)
                    begin
                        dq_out[l*8 +: 8]         <= ~rd_data_in[l*8 +: 8];
                        bus_inversion_low_out[l] <= 1'b0;
                    end
            end
            case (width_cfg_in)
                sdram_sig_pkg::WIDTH_X4:  dq_oe_out <= {16{rd_valid_in}} & 16'h000F;
                sdram_sig_pkg::WIDTH_X8:  dq_oe_out <= {16{rd_valid_in}} & 16'h00FF;
                default:                  dq_oe_out <= {16{rd_valid_in}};
            endcase
            strobe_oe_out   <= {is_x16 & rd_valid_in, rd_valid_in};
            strobe_true_out <= {2{rd_valid_in & ~strobe_true_out[0]}};
            strobe_comp_out <= ~{2{rd_valid_in & ~strobe_true_out[0]}};
        end
    end

    // =========================================
    // Alert and temperature event
    alert_state_t alert_state_ff;
    logic [7:0]   alert_cnt_ff;
    logic [1:0]   alert_pin_sync_ff;
    logic [1:0]   temp_sync_ff;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst)
        begin
            alert_state_ff <= ALERT_IDLE;
            alert_cnt_ff   <= 8'h0;
        end
        else
        begin
            case (alert_state_ff)
                ALERT_IDLE:
                begin
                    if (parity_err_out)
                    begin
                        alert_state_ff <= ALERT_PAR;
                        alert_cnt_ff   <= 8'(sdram_sig_pkg::PAR_RECOV_CYC - 1);
                    end
                    else if (crc_err_out)
                    begin
                        alert_state_ff <= ALERT_CRC;
                        alert_cnt_ff   <= 8'(sdram_sig_pkg::CRC_ALERT_CYC - 1);
                    end
                end
                ALERT_CRC:
                begin
                    if (parity_err_out)
                    begin
                        alert_state_ff <= ALERT_PAR;
                        alert_cnt_ff   <= 8'(sdram_sig_pkg::PAR_RECOV_CYC - 1);
                    end
                    else if (alert_cnt_ff == 8'h0)
                        alert_state_ff <= ALERT_IDLE;
                    else
                        alert_cnt_ff <= alert_cnt_ff - 8'h1;
                end
                ALERT_PAR:
                begin
                    if (alert_cnt_ff == 8'h0)
                        alert_state_ff <= ALERT_IDLE;
                    else
                        alert_cnt_ff <= alert_cnt_ff - 8'h1;
                end
                default: alert_state_ff <= ALERT_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst)
        begin
            alert_pin_sync_ff <= 2'h3;
            temp_sync_ff      <= 2'h0;
            alert_seen_out    <= 1'b0;
            event_low_out     <= 1'b1;
        end
        else
        begin
            alert_pin_sync_ff <= {alert_pin_sync_ff[0], alert_low_pin_in};
            temp_sync_ff      <= {temp_sync_ff[0], temp_critical_in};
            alert_seen_out    <= conn_test_in & ~alert_pin_sync_ff[1];
            event_low_out     <= ~temp_sync_ff[1];
        end
    end

    assign alert_low_out    = (alert_state_ff == ALERT_IDLE);
    assign alert_low_oe_out = ~conn_test_in;

    // =========================================
    // Checks
    // The low time of alert is counted here, since a long repetition is costly to check.
    logic [7:0] low_run_ff;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst || alert_low_out)
            low_run_ff <= 8'h0;
        else
            low_run_ff <= low_run_ff + 8'h1;
    end

    a_odt_gate: assert property (@(posedge ref_clk_in) disable iff (rst)
        !termination_enable_in |=> !termination_resistance_out)
        else $error("termination on while disabled");
    a_odt_follow: assert property (@(posedge ref_clk_in) disable iff (rst)
        termination_enable_in && odt_sync_ff[1] |=> termination_resistance_out)
        else $error("termination not applied");
    a_cs_ignore: assert property (@(posedge ref_clk_in) disable iff (rst)
        chip_select_low_in |=> !cmd_valid_out && !parity_err_out)
        else $error("command taken with select high");
    a_par_flag: assert property (@(posedge ref_clk_in) disable iff (rst)
        !chip_select_low_in && par_en && ((^ca_vec) != parity_in) |=> parity_err_out)
        else $error("parity error missed");
    a_par_alert: assert property (@(posedge ref_clk_in) disable iff (rst)
        $rose(parity_err_out) |=> !alert_low_out [*8])
        else $error("alert released early on parity");
    a_crc_alert: assert property (@(posedge ref_clk_in) disable iff (rst)
        $rose(alert_low_out) && $past(alert_state_ff == ALERT_CRC)
        |-> low_run_ff == 8'(sdram_sig_pkg::CRC_ALERT_CYC))
        else $error("crc alert interval wrong");
    a_tdqs_only: assert property (@(posedge ref_clk_in) disable iff (rst)
        !is_x8 |=> !term_strobe_term_out)
        else $error("term strobe outside x8");
    a_alert_dir: assert property (@(posedge ref_clk_in) disable iff (rst)
        conn_test_in |-> !alert_low_oe_out)
        else $error("alert driven in test mode");
endmodule : sdram_module_signal_logic
`default_nettype wire

// ===== verification/link_host_model.sv
// Host side of the strobe link: one eight-beat write burst per rise of go_in.
// Assumes go_in is raised only while the link is idle.
`timescale 1ns/1ps
`default_nettype none
module link_host_model
(
    input  wire logic        go_in,
    output logic             link_clk_out,
    output logic             link_start_out,
    output logic [15:0]      dq_rise_out,
    output logic [15:0]      dq_fall_out,
    output logic [1:0]       mask_fall_out
);
    // ==========================================================
    // Burst driver. The clock stands still between bursts.
    initial
    begin
        link_clk_out = 1'b0;
        link_start_out = 1'b0;
        dq_rise_out = 16'hA5A5;
        dq_fall_out = 16'h5A5A;
        mask_fall_out = 2'h3;
    end
    always @(posedge go_in)
    begin
        for (int e = 0; e < 6; e++)
        begin
            link_start_out = (e == 0);
            dq_rise_out = {2{8'(14 + 2 * e)}};
            dq_fall_out = {2{8'(15 + 2 * e)}};
            mask_fall_out = (e == 2) ? 2'h2 : 2'h3;
            #16 link_clk_out = 1'b1;
            #32 link_clk_out = 1'b0;
            #16;
        end
        dq_rise_out = ~dq_rise_out;
        dq_fall_out = ~dq_fall_out;
    end
endmodule : link_host_model
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the module pin logic.
// Assumes an x16 part with CRC on; the link host model drives write bursts.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk_in = 1'b0, go = 1'b0, rd_valid_in = 1'b0, parity_in = 1'b0;
    logic reset_in = 1'b1, reset_low_in = 1'b1, termination_enable_in = 1'b1;
    logic termination_control_in = 1'b0, chip_select_low_in = 1'b1, conn_test_in = 1'b0;
    logic activate_select_in, row_strobe_addr_hi_in, column_strobe_addr_mid_in;
    logic write_strobe_addr_lo_in, alert_low_pin_in = 1'b1, temp_critical_in = 1'b0;
    logic [17:0] mode_reg_one_in = '0, mode_reg_two_in = 18'h01000, mode_reg_four_in = 18'h10;
    logic [17:0] mode_reg_five_in = 18'h01401;
    logic [1:0] width_cfg_in = 2'h2, bank_group_bits_in, bank_bits_in;
    logic [1:0] bus_inversion_low_rise_in = 2'h3, bus_inversion_low_fall_in = 2'h3;
    logic [13:0] addr_low_in;
    logic [15:0] rd_data_in = '0, dq_rise_in, dq_fall_in, dq_out, dq_oe_out, wr_keep_out;
    logic link_clk_in, link_start_in, term_strobe_oe_out, termination_resistance_out;
    logic [1:0] write_mask_low_fall_in, bus_inversion_low_out, strobe_true_out;
    logic [1:0] strobe_comp_out, strobe_oe_out, lane_term_out;
    logic term_strobe_term_out, vref_monitor_out, alert_low_out, alert_low_oe_out;
    logic alert_seen_out, event_low_out, cmd_valid_out, parity_err_out, crc_err_out;
    logic wr_valid_out;
    logic [3:0] cmd_code_out;
    logic [16:0] row_addr_out;
    logic [127:0] wr_data_out;
    int num_errors = 0;
    int n_compared = 0;
    // ==========================================================
    // Clock, partner and design.
    always #4 ref_clk_in = ~ref_clk_in;
    link_host_model host (.go_in(go), .link_clk_out(link_clk_in), .link_start_out(link_start_in),
        .dq_rise_out(dq_rise_in), .dq_fall_out(dq_fall_in), .mask_fall_out(write_mask_low_fall_in));
    sdram_module_signal_logic uut (.write_mask_low_rise_in(2'h3), .*);
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_alert(input string what, input int cyc);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        while (alert_low_out === 1'b0 && n < 60)
        begin
            n++;
            @(negedge ref_clk_in);
        end
        chk(what, cyc, n);
    endtask : chk_alert
    task automatic send_cmd(input logic cs, input logic [21:0] ca, input logic par);
        @(negedge ref_clk_in);
        chip_select_low_in = cs;
        parity_in = par;
        {activate_select_in, row_strobe_addr_hi_in, column_strobe_addr_mid_in,
            write_strobe_addr_lo_in, bank_group_bits_in, bank_bits_in, addr_low_in} = ca;
        @(negedge ref_clk_in);
        chip_select_low_in = 1'b1;
    endtask : send_cmd
    task automatic test_cmd();
        send_cmd(1'b0, 22'h05F234, ^22'h05F234);
        chk("row", 64'h27234, {46'h0, cmd_valid_out, row_addr_out});
        send_cmd(1'b0, 22'h340000, ^22'h340000);
        chk("code", 64'h15, {cmd_valid_out, cmd_code_out});
        send_cmd(1'b1, 22'h340000, ^22'h340000);
        chk("ignored", 64'h0, {cmd_valid_out, parity_err_out});
        chk("vref", 64'h1, vref_monitor_out);
        {temp_critical_in, conn_test_in, alert_low_pin_in} = 3'h6;
        repeat (4) @(negedge ref_clk_in);
        chk("event", 64'h0, event_low_out);
        chk("alert_in", 64'h2, {alert_seen_out, alert_low_oe_out});
        {temp_critical_in, conn_test_in, alert_low_pin_in} = 3'h1;
        $display("test_cmd done");
    endtask : test_cmd
    task automatic test_parity();
        send_cmd(1'b0, 22'h05F234, ~^22'h05F234);
        chk("par_err", 64'h1, parity_err_out);
        chk_alert("alert_len", sdram_sig_pkg::PAR_RECOV_CYC);
        $display("test_parity done");
    endtask : test_parity
    task automatic test_pin_reset();
        send_cmd(1'b0, 22'h05F234, ~^22'h05F234);
        reset_low_in = 1'b0;
        @(negedge ref_clk_in);
        chk("rst_alert", 64'h1, {parity_err_out, alert_low_out});
        reset_low_in = 1'b1;
        repeat (3) @(negedge ref_clk_in);
        $display("test_pin_reset done");
    endtask : test_pin_reset
    task automatic test_term(input logic en);
        termination_enable_in = en;
        termination_control_in = 1'b1;
        repeat (6) @(negedge ref_clk_in);
        chk("term", en, termination_resistance_out);
        chk("lane_term", {en, en}, lane_term_out);
        termination_control_in = 1'b0;
        repeat (6) @(negedge ref_clk_in);
        chk("term_off", 64'h0, termination_resistance_out);
        $display("test_term done");
    endtask : test_term
    task automatic test_write();
        int n;
        n = 0;
        go = 1'b1;
        while (wr_valid_out !== 1'b1 && n < 100)
        begin
            n++;
            @(posedge ref_clk_in);
            #1;
        end
        go = 1'b0;
        chk("keep", 64'hFFF7, wr_keep_out);
        chk("lane1", 64'h1716151413121110, wr_data_out[127:64]);
        chk("crc_err", 64'h1, crc_err_out);
        chk_alert("crc_alert", sdram_sig_pkg::CRC_ALERT_CYC);
        $display("test_write done");
    endtask : test_write
    task automatic test_read();
        @(negedge ref_clk_in);
        rd_data_in = 16'h00FF;
        rd_valid_in = 1'b1;
        @(negedge ref_clk_in);
        rd_valid_in = 1'b0;
        chk("rd_dq", 64'h0, dq_out);
        chk("rd_inv", 64'h2, bus_inversion_low_out);
        chk("rd_oe", 64'hFFFF, dq_oe_out);
        chk("rd_dqs", 64'h3, strobe_oe_out);
        $display("test_read done");
    endtask : test_read
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        #200000;
        num_errors++;
        give_verdict();
    end
    initial
    begin
        repeat (3) @(negedge ref_clk_in);
        reset_in = 1'b0;
        repeat (3) @(negedge ref_clk_in);
        test_cmd();
        test_parity();
        test_pin_reset();
        test_term(1'b1);
        test_term(1'b0);
        test_write();
        mode_reg_five_in = 18'h01000;
        test_read();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
